// *** design/frpg_delay_timer.v ***
// Delay timer: decoded multiplier times delay unit, in clk_sys cycles.
// Assumes the unit length input is stable while a delay runs.
`timescale 1ns/1ps
module frpg_delay_timer #(
    parameter UNIT_W = 16
)
(
    input wire clk_sys,
    input wire sys_rst,
    input wire start,
    input wire [2:0] delay_code,
    input wire [UNIT_W-1:0] unit_cycles,
    output wire expired
);
    localparam CNT_W = UNIT_W + 8;

    reg [CNT_W-1:0] cnt_q;
    reg run_q;
    wire [CNT_W-1:0] total;
    wire [UNIT_W-1:0] unit_safe;

    function [7:0] frpg_mult;
        input [2:0] code;
        begin
            case (code)
                3'h0: frpg_mult = 8'h01;
                3'h1: frpg_mult = 8'h02;
                3'h2: frpg_mult = 8'h04;
                3'h3: frpg_mult = 8'h08;
                3'h4: frpg_mult = 8'h10;
                3'h5: frpg_mult = 8'h20;
                3'h6: frpg_mult = 8'h40;
                default: frpg_mult = 8'h80;
            endcase
        end
    endfunction

    // A zero unit would never expire; treat it as one cycle
    assign unit_safe = (unit_cycles == {UNIT_W{1'b0}}) ?
        {{(UNIT_W-1){1'b0}}, 1'b1} : unit_cycles;
    assign total = frpg_mult(delay_code) * unit_safe;
    assign expired = run_q && (cnt_q == {CNT_W{1'b0}});

    always @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            cnt_q <= {CNT_W{1'b0}};
            run_q <= 1'b0;
        end
        else if (start)
        begin
            cnt_q <= total - {{(CNT_W-1){1'b0}}, 1'b1};
            run_q <= 1'b1;
        end
        else if (cnt_q != {CNT_W{1'b0}})
        begin
            cnt_q <= cnt_q - {{(CNT_W-1){1'b0}}, 1'b1};
        end
    end
endmodule // frpg_delay_timer

// *** design/frpg_map.vh ***
// Constants for the fault retry and power-ok block.
// Assumes a front end that decodes management transfers to command codes.
// Summary of operation
// - Retry field values two through six give exactly that many restart attempts.
// - When all permitted attempts fail, output stays off until fault cleared.
// - Spacing between attempt starts equals decoded delay count times delay unit.
// - Retry field all ones retries without any limit.
// - Unlimited retry ends on command off, bias loss or another shutdown.
// - Delay field decodes 0..7 to 1,2,(4),8,16,32,64,128 delay units.
// - Same decoded delay sets how long operation continues after a fault.
// - Delay unit length comes from a separate configuration input.
// - Power-ok asserts once output voltage reaches the assert threshold.
// - Power-ok pin negates below negate threshold only when pin function enabled.
// - Output voltage below negate threshold sets the power-ok status bit.
// - Both thresholds are read and written with word transfers.
// - Retry field zero means no restart; output stays off until cleared.
// - Response value binary ten disables output then follows retry setting.
// - Latched fault clears by bit clear, clear command, reset, off-on, bias loss.
`ifndef FRPG_MAP_VH
`define FRPG_MAP_VH

// Command codes of the threshold settings
`define FRPG_CMD_POK_ASSERT 8'h5e
`define FRPG_CMD_POK_NEGATE 8'h5f

// Threshold reset values
`define FRPG_POK_ASSERT_RST 16'h0000
`define FRPG_POK_NEGATE_RST 16'h0000

// Fault response byte fields
`define FRPG_RESP_HI 7
`define FRPG_RESP_LO 6
`define FRPG_RETRY_HI 5
`define FRPG_RETRY_LO 3
`define FRPG_DELAY_HI 2
`define FRPG_DELAY_LO 0

// Response encodings
`define FRPG_RESP_IGNORE 2'h0
`define FRPG_RESP_CONTINUE 2'h1
`define FRPG_RESP_RETRY 2'h2
`define FRPG_RESP_LATCH 2'h3

// Retry field special values
`define FRPG_RETRY_NONE 3'h0
`define FRPG_RETRY_FOREVER 3'h7

// Power-ok enable bit in the pin function configuration
`define FRPG_PINCFG_POK_EN 0

`endif

// *** design/frpg_power_ok.v ***
// Power-ok comparator with hysteresis between two thresholds.
// Assumes vout is a sampled code in the same format as the thresholds.
`timescale 1ns/1ps
module frpg_power_ok (
    input wire clk_sys,
    input wire sys_rst,
    input wire [15:0] vout,
    input wire [15:0] assert_thr,
    input wire [15:0] negate_thr,
    output reg good_q,
    output wire below_negate
);
    wire reach_assert;

    assign reach_assert = (vout >= assert_thr);
    assign below_negate = (vout < negate_thr);

    always @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            good_q <= 1'b0;
        end
        else if (below_negate)
        begin
            // Negate wins if thresholds are programmed crossed
            good_q <= 1'b0;
        end
        else if (reach_assert)
        begin
            good_q <= 1'b1;
        end
    end
endmodule // frpg_power_ok

// *** design/frpg_top.v ***
// Fault retry sequencer and power-ok logic of a managed converter.
// Assumes decoded management transfers and pulsed fault inputs on clk_sys.
`timescale 1ns/1ps
`include "frpg_map.vh"
module frpg_top #(
    parameter UNIT_W = 16
)
(
    input wire clk_sys,
    input wire sys_rst,
    input wire cmd_valid,
    input wire cmd_write,
    input wire cmd_word,
    input wire [7:0] cmd_code,
    input wire [15:0] cmd_wdata,
    output reg cmd_ack_q,
    output reg cmd_nack_q,
    output reg [15:0] cmd_rdata_q,
    input wire [7:0] fault_response,
    input wire [UNIT_W-1:0] delay_unit_cycles,
    input wire [7:0] pin_function_config,
    input wire fault_event,
    input wire fault_present,
    input wire restart_done,
    input wire bit_clear,
    input wire clear_faults,
    input wire output_cmd_on,
    input wire bias_lost,
    input wire other_shutdown,
    input wire [15:0] vout,
    output reg output_enable_q,
    output reg fault_latched_q,
    output reg [2:0] seq_state_q,
    output reg [7:0] attempts_q,
    output wire power_ok_pin,
    output reg power_ok_status_q
);
    localparam ST_OFF = 3'h0;
    localparam ST_RUN = 3'h1;
    localparam ST_CONT = 3'h2;
    localparam ST_WAIT = 3'h3;
    localparam ST_TRY = 3'h4;
    localparam ST_LATCH = 3'h5;

    reg [15:0] pok_assert_q;
    reg [15:0] pok_negate_q;
    reg [2:0] state_d;
    reg [7:0] attempts_d;
    reg timer_start;
    reg [2:0] retry_set_q;
    reg [2:0] delay_set_q;
    wire [1:0] resp_mode;
    wire timer_expired;
    wire pok_good;
    wire pok_below;
    wire clear_req;
    wire stop_req;
    wire retry_left;
    wire [2:0] delay_use;

    assign resp_mode = fault_response[`FRPG_RESP_HI:`FRPG_RESP_LO];

    // Settings captured at fault entry so a mid-sequence rewrite is not
    // mixed into a running sequence
    always @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            retry_set_q <= `FRPG_RETRY_NONE;
            delay_set_q <= 3'h0;
        end
        else if (fault_event && (seq_state_q == ST_RUN))
        begin
            retry_set_q <= fault_response[`FRPG_RETRY_HI:`FRPG_RETRY_LO];
            delay_set_q <= fault_response[`FRPG_DELAY_HI:`FRPG_DELAY_LO];
        end
    end

    // Threshold settings, word transfers only
    always @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            pok_assert_q <= `FRPG_POK_ASSERT_RST;
            pok_negate_q <= `FRPG_POK_NEGATE_RST;
            cmd_ack_q <= 1'b0;
            cmd_nack_q <= 1'b0;
            cmd_rdata_q <= 16'h0000;
        end
        else
        begin
            cmd_ack_q <= 1'b0;
            cmd_nack_q <= 1'b0;
            if (cmd_valid)
            begin
                if (!cmd_word)
                begin
                    // Byte transfers to word settings are refused
                    cmd_nack_q <= 1'b1;
                end
                else if (cmd_code == `FRPG_CMD_POK_ASSERT)
                begin
                    cmd_ack_q <= 1'b1;
                    if (cmd_write)
                    begin
                        pok_assert_q <= cmd_wdata;
                    end
                    else
                    begin
                        cmd_rdata_q <= pok_assert_q;
                    end
                end
                else if (cmd_code == `FRPG_CMD_POK_NEGATE)
                begin
                    cmd_ack_q <= 1'b1;
                    if (cmd_write)
                    begin
                        pok_negate_q <= cmd_wdata;
                    end
                    else
                    begin
                        cmd_rdata_q <= pok_negate_q;
                    end
                end
                else
                begin
                    cmd_nack_q <= 1'b1;
                end
            end
        end
    end

    frpg_power_ok u_pok (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .vout(vout),
        .assert_thr(pok_assert_q),
        .negate_thr(pok_negate_q),
        .good_q(pok_good),
        .below_negate(pok_below)
    );

    // Pin only carries the function when the config enables it
    assign power_ok_pin = pok_good &&
        pin_function_config[`FRPG_PINCFG_POK_EN];

    // Sticky; a new drop in the clear cycle still sets it
    always @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            power_ok_status_q <= 1'b0;
        end
        else if (pok_below)
        begin
            power_ok_status_q <= 1'b1;
        end
        else if (clear_faults || bit_clear || bias_lost)
        begin
            power_ok_status_q <= 1'b0;
        end
    end

    // A start from run shares its edge with the capture: use the live field
    assign delay_use = (seq_state_q == ST_RUN) ?
        fault_response[`FRPG_DELAY_HI:`FRPG_DELAY_LO] : delay_set_q;

    frpg_delay_timer #(
        .UNIT_W(UNIT_W)
    ) u_timer (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .start(timer_start),
        .delay_code(delay_use),
        .unit_cycles(delay_unit_cycles),
        .expired(timer_expired)
    );

    assign clear_req = bit_clear || clear_faults;
    assign stop_req = !output_cmd_on || bias_lost;
    // Unlimited retry keeps going; otherwise compare against the field
    assign retry_left = (retry_set_q == `FRPG_RETRY_FOREVER) ||
        (attempts_q < {5'h00, retry_set_q});

    always @*
    begin
        state_d = seq_state_q;
        attempts_d = attempts_q;
        timer_start = 1'b0;
        case (seq_state_q)
            ST_OFF:
            begin
                attempts_d = 8'h00;
                if (output_cmd_on && !bias_lost)
                begin
                    state_d = ST_RUN;
                end
            end
            ST_RUN:
            begin
                attempts_d = 8'h00;
                if (fault_event)
                begin
                    case (resp_mode)
                        `FRPG_RESP_CONTINUE:
                        begin
                            state_d = ST_CONT;
                            timer_start = 1'b1;
                        end
                        `FRPG_RESP_RETRY:
                        begin
                            state_d = ST_WAIT;
                            timer_start = 1'b1;
                        end
                        `FRPG_RESP_LATCH:
                        begin
                            state_d = ST_LATCH;
                        end
                        default:
                        begin
                            state_d = ST_RUN;
                        end
                    endcase
                end
            end
            ST_CONT:
            begin
                if (timer_expired)
                begin
                    if (fault_present)
                    begin
                        state_d = ST_WAIT;
                        timer_start = 1'b1;
                    end
                    else
                    begin
                        state_d = ST_RUN;
                    end
                end
            end
            ST_WAIT:
            begin
                if (timer_expired)
                begin
                    if (retry_left)
                    begin
                        state_d = ST_TRY;
                        attempts_d = attempts_q + 8'h01;
                        // Spacing measured start to start
                        timer_start = 1'b1;
                    end
                    else
                    begin
                        state_d = ST_LATCH;
                    end
                end
            end
            ST_TRY:
            begin
                if (fault_event)
                begin
                    state_d = ST_WAIT;
                end
                else if (restart_done)
                begin
                    state_d = ST_RUN;
                end
            end
            ST_LATCH:
            begin
                if (clear_req)
                begin
                    state_d = ST_OFF;
                end
            end
            default:
            begin
                state_d = ST_OFF;
            end
        endcase
        // Command off or bias loss override all; another shutdown latches from any state but off
        if (stop_req)
        begin
            state_d = ST_OFF;
            attempts_d = 8'h00;
        end
        else if (other_shutdown && (seq_state_q != ST_OFF))
        begin
            state_d = ST_LATCH;
        end
    end

    always @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            seq_state_q <= ST_OFF;
            attempts_q <= 8'h00;
            output_enable_q <= 1'b0;
            fault_latched_q <= 1'b0;
        end
        else
        begin
            seq_state_q <= state_d;
            // Saturate rather than wrap in unlimited mode
            if (attempts_d != 8'h00 || state_d != ST_TRY)
            begin
                attempts_q <= (attempts_q == 8'hff &&
                    attempts_d == 8'h00 && state_d == ST_TRY) ?
                    8'hff : attempts_d;
            end
            output_enable_q <= (state_d == ST_RUN) ||
                (state_d == ST_CONT) || (state_d == ST_TRY);
            fault_latched_q <= (state_d == ST_LATCH);
        end
    end
endmodule // frpg_top

// *** tb/frpg_host_model.sv ***
// Management host model: issues decoded word and byte transfers.
// Assumes the device answers on the same clk_sys edge that takes the transfer.
`timescale 1ns/1ps
module frpg_host_model (
    input wire clk_sys,
    output logic cmd_valid,
    output logic cmd_write,
    output logic cmd_word,
    output logic [7:0] cmd_code,
    output logic [15:0] cmd_wdata,
    input wire cmd_ack_q,
    input wire cmd_nack_q,
    input wire [15:0] cmd_rdata_q
);
    initial
    begin
        {cmd_valid, cmd_write, cmd_word} = 3'h0;
        {cmd_code, cmd_wdata} = 24'h000000;
    end
    task xfer(input logic wr, input logic word, input logic [7:0] code,
        input logic [15:0] wd, output logic ack, output logic nack,
        output logic [15:0] rd);
        @(posedge clk_sys);
        #1;
        {cmd_valid, cmd_write, cmd_word} = {1'b1, wr, word};
        {cmd_code, cmd_wdata} = {code, wd};
        @(posedge clk_sys);
        #1;
        {ack, nack, rd} = {cmd_ack_q, cmd_nack_q, cmd_rdata_q};
        // Stale qualifiers flip so leftovers never look like a request
        {cmd_valid, cmd_write, cmd_word} = {1'b0, ~wr, ~word};
        {cmd_code, cmd_wdata} = {~code, ~wd};
    endtask
endmodule // frpg_host_model

// *** tb/frpg_top_assertions.sv ***
// Port-level checker for the fault retry and power-ok block.
// Assumes it is bound to frpg_top; thresholds are mirrored from writes.
`timescale 1ns/1ps
module frpg_top_assertions (
    input wire clk_sys,
    input wire sys_rst,
    input wire cmd_valid,
    input wire cmd_write,
    input wire cmd_word,
    input wire [7:0] cmd_code,
    input wire [15:0] cmd_wdata,
    input wire cmd_ack_q,
    input wire cmd_nack_q,
    input wire [7:0] fault_response,
    input wire [7:0] pin_function_config,
    input wire fault_event,
    input wire bit_clear,
    input wire clear_faults,
    input wire output_cmd_on,
    input wire bias_lost,
    input wire other_shutdown,
    input wire [15:0] vout,
    input wire output_enable_q,
    input wire fault_latched_q,
    input wire [2:0] seq_state_q,
    input wire [7:0] attempts_q,
    input wire power_ok_pin,
    input wire power_ok_status_q
);
    logic [15:0] thr_a_q;
    logic [15:0] thr_n_q;
    logic wr_q;
    wire hit = cmd_code == 8'h5e || cmd_code == 8'h5f;
    wire take = cmd_valid && cmd_word && hit && cmd_write;
    // One cycle of slack after writes: storage edge is not pinned down
    wire steady = !cmd_valid && !wr_q;
    wire go = output_cmd_on && !bias_lost && !other_shutdown;
    always @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
            {thr_a_q, thr_n_q, wr_q} <= 33'h0;
        else
        begin
            wr_q <= cmd_valid;
            if (take && !cmd_code[0])
                thr_a_q <= cmd_wdata;
            if (take && cmd_code[0])
                thr_n_q <= cmd_wdata;
        end
    end
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);
    property p_ack;
        cmd_valid && cmd_word && hit |=> cmd_ack_q && !cmd_nack_q;
    endproperty
    a_ack: assert property (p_ack) else $error("ack missing");
    property p_nack;
        cmd_valid && !(cmd_word && hit) |=> cmd_nack_q && !cmd_ack_q;
    endproperty
    a_nack: assert property (p_nack) else $error("nack missing");
    property p_pok_on;
        steady && vout >= thr_a_q && vout >= thr_n_q
            |=> power_ok_pin == pin_function_config[0];
    endproperty
    a_pok_on: assert property (p_pok_on) else $error("pok not set");
    property p_pok_hold;
        steady && power_ok_pin && vout >= thr_n_q
            |=> power_ok_pin == pin_function_config[0];
    endproperty
    a_pok_hold: assert property (p_pok_hold) else $error("pok lost");
    property p_pok_off;
        steady && vout < thr_n_q |=> !power_ok_pin;
    endproperty
    a_pok_off: assert property (p_pok_off) else $error("pok held");
    property p_status;
        steady && vout < thr_n_q |=> power_ok_status_q;
    endproperty
    a_status: assert property (p_status) else $error("status not set");
    property p_latch_off;
        fault_latched_q |-> !output_enable_q;
    endproperty
    a_latch_off: assert property (p_latch_off) else $error("latched on");
    property p_retry_entry;
        seq_state_q == 3'h1 && fault_event && fault_response[7:6] == 2'h2
            && go |=> seq_state_q == 3'h3 && !output_enable_q;
    endproperty
    a_retry_entry: assert property (p_retry_entry) else $error("no off");
    property p_stop;
        !output_cmd_on || bias_lost
            |=> seq_state_q == 3'h0 && attempts_q == 8'h00 && !output_enable_q;
    endproperty
    a_stop: assert property (p_stop) else $error("stop ignored");
    property p_attempt;
        seq_state_q == 3'h4 && $past(seq_state_q) == 3'h3
            |-> attempts_q == $past(attempts_q) + 8'h01;
    endproperty
    a_attempt: assert property (p_attempt) else $error("bad count");
    property p_clear;
        seq_state_q == 3'h5 && (bit_clear || clear_faults) && go
            |=> !fault_latched_q;
    endproperty
    a_clear: assert property (p_clear) else $error("clear ignored");
    c_retry: cover property (seq_state_q == 3'h4 ##1 seq_state_q == 3'h3);
    c_latch: cover property ($rose(fault_latched_q));
    c_pok: cover property ($fell(power_ok_pin));
endmodule // frpg_top_assertions
bind frpg_top frpg_top_assertions i_frpg_top_assertions (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .cmd_valid(cmd_valid),
    .cmd_write(cmd_write), .cmd_word(cmd_word), .cmd_code(cmd_code),
    .cmd_wdata(cmd_wdata), .cmd_ack_q(cmd_ack_q), .cmd_nack_q(cmd_nack_q),
    .fault_response(fault_response), .fault_event(fault_event),
    .pin_function_config(pin_function_config), .bit_clear(bit_clear),
    .clear_faults(clear_faults), .output_cmd_on(output_cmd_on),
    .bias_lost(bias_lost), .other_shutdown(other_shutdown), .vout(vout),
    .output_enable_q(output_enable_q), .fault_latched_q(fault_latched_q),
    .seq_state_q(seq_state_q), .attempts_q(attempts_q),
    .power_ok_pin(power_ok_pin), .power_ok_status_q(power_ok_status_q));

// *** tb/frpg_top_bench.sv ***
// Self-checking bench for the fault retry and power-ok block.
// Assumes frpg_host_model drives the decoded management port.
`timescale 1ns/1ps
module frpg_top_bench;
    localparam int UNIT = 2;
    typedef struct packed {
        logic wr;
        logic word;
        logic [7:0] code;
        logic [15:0] wd;
        logic ack;
        logic [15:0] rd;
    } frpg_row_t;
    frpg_row_t rows [8] = '{'{0, 1, 8'h5e, 0, 1, 0},
        '{1, 1, 8'h5e, 16'h1000, 1, 0}, '{1, 1, 8'h5f, 16'h0800, 1, 0},
        '{0, 1, 8'h5e, 0, 1, 16'h1000}, '{0, 1, 8'h5f, 0, 1, 16'h0800},
        '{1, 0, 8'h5e, 16'hffff, 0, 0}, '{0, 1, 8'h5e, 0, 1, 16'h1000},
        '{1, 1, 8'h60, 16'h1234, 0, 0}};
    int mult [8] = '{1, 2, 4, 8, 16, 32, 64, 128};
    int fails = 0;
    int checks_done = 0;
    int i;
    int n;
    logic clk_sys, sys_rst, fault_event, fault_present, restart_done;
    logic bit_clear, clear_faults, output_cmd_on, bias_lost, other_shutdown;
    logic cmd_valid, cmd_write, cmd_word, cmd_ack_q, cmd_nack_q, ack, nack;
    logic output_enable_q, fault_latched_q, power_ok_pin, power_ok_status_q;
    logic [7:0] cmd_code, fault_response, pin_function_config, attempts_q;
    logic [15:0] cmd_wdata, cmd_rdata_q, vout, rd, unit_cyc;
    logic [2:0] seq_state_q;
    frpg_host_model i_frpg_host_model (.clk_sys(clk_sys),
        .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_word(cmd_word),
        .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .cmd_ack_q(cmd_ack_q),
        .cmd_nack_q(cmd_nack_q), .cmd_rdata_q(cmd_rdata_q));
    frpg_top #(.UNIT_W(16)) i_frpg_top (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_word(cmd_word),
        .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .cmd_ack_q(cmd_ack_q),
        .cmd_nack_q(cmd_nack_q), .cmd_rdata_q(cmd_rdata_q),
        .fault_response(fault_response), .delay_unit_cycles(unit_cyc),
        .pin_function_config(pin_function_config), .fault_event(fault_event),
        .fault_present(fault_present), .restart_done(restart_done),
        .bit_clear(bit_clear), .clear_faults(clear_faults),
        .output_cmd_on(output_cmd_on), .bias_lost(bias_lost),
        .other_shutdown(other_shutdown), .vout(vout),
        .output_enable_q(output_enable_q), .fault_latched_q(fault_latched_q),
        .seq_state_q(seq_state_q), .attempts_q(attempts_q),
        .power_ok_pin(power_ok_pin), .power_ok_status_q(power_ok_status_q));
    initial
    begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    task stop_test;
        if (fails == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task tick;
        @(posedge clk_sys);
        #1;
    endtask
    task chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            fails++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Timing kept to one cycle of slack: the expiry edge is loosely pinned
    task near(input int got, input int exp);
        checks_done++;
        if (got < exp - 1 || got > exp + 1)
        begin
            fails++;
            $display("[ERR] %0t took %0d cycles, expected %0d", $time, got, exp);
        end
    endtask
    task pf(input int k);
        case (k)
            0: fault_event = 1'b1;
            1: restart_done = 1'b1;
            2: clear_faults = 1'b1;
            3: bit_clear = 1'b1;
            default: other_shutdown = 1'b1;
        endcase
        tick;
        {fault_event, restart_done, clear_faults} = 3'h0;
        {bit_clear, other_shutdown} = 2'h0;
    endtask
    task wait_state(input logic [2:0] s, output int c);
        c = 0;
        while (seq_state_q !== s && c < 400)
        begin
            tick;
            c++;
        end
    endtask
    task pok(input logic [15:0] v, input logic pin, input logic stat);
        vout = v;
        tick;
        tick;
        chk({power_ok_pin, power_ok_status_q}, {pin, stat});
    endtask
    // Attempt k fails unless k equals ok; delay code 3 gives 8 units
    task retry(input logic [2:0] r, input int cnt, input int ok);
        int c;
        int k;
        fault_response = {2'b10, r, 3'h3};
        pf(0);
        chk({seq_state_q, output_enable_q}, 4'h6);
        for (k = 1; k <= cnt; k++)
        begin
            wait_state(3'h4, c);
            near(c + (k > 1), 8 * UNIT);
            chk({attempts_q, output_enable_q}, {k[7:0], 1'b1});
            pf(k == ok);
        end
    endtask
    initial
    begin
        repeat (20000) @(posedge clk_sys);
        fails++;
        stop_test;
    end
    initial
    begin
        sys_rst = 1'b1;
        {fault_event, fault_present, restart_done, bit_clear} = 4'h0;
        {clear_faults, bias_lost, other_shutdown, output_cmd_on} = 4'h1;
        {fault_response, pin_function_config, vout} = 32'h00010000;
        unit_cyc = 16'(UNIT);
        repeat (20) @(posedge clk_sys);
        #1;
        chk({output_enable_q, fault_latched_q, power_ok_pin,
            power_ok_status_q, cmd_ack_q, attempts_q, seq_state_q}, 0);
        sys_rst = 1'b0;
        tick;
        chk({seq_state_q, output_enable_q}, 4'h3);
        for (i = 0; i < 8; i++)
        begin
            i_frpg_host_model.xfer(rows[i].wr, rows[i].word, rows[i].code,
                rows[i].wd, ack, nack, rd);
            chk({ack, nack}, {rows[i].ack, ~rows[i].ack});
            if (!rows[i].wr && rows[i].ack)
                chk(rd, rows[i].rd);
        end
        pok(16'h1000, 1'b1, 1'b1);
        pf(2);
        pok(16'h0900, 1'b1, 1'b0);
        pok(16'h0800, 1'b1, 1'b0);
        pok(16'h07ff, 1'b0, 1'b1);
        pok(16'h0fff, 1'b0, 1'b1);
        pin_function_config = 8'h00;
        pok(16'h1000, 1'b0, 1'b1);
        pin_function_config = 8'h01;
        for (i = 0; i < 8; i++)
        begin
            fault_response = {5'h08, i[2:0]};
            pf(0);
            chk({seq_state_q, output_enable_q}, 4'h5);
            wait_state(3'h1, n);
            near(n, mult[i] * UNIT);
        end
        fault_present = 1'b1;
        unit_cyc = 16'h0003;
        fault_response = 8'h40;
        pf(0);
        wait_state(3'h3, n);
        near(n, 3);
        wait_state(3'h5, n);
        chk({fault_latched_q, output_enable_q}, 2'h2);
        fault_present = 1'b0;
        unit_cyc = 16'(UNIT);
        pf(3);
        wait_state(3'h1, n);
        chk(seq_state_q, 3'h1);
        retry(3'h2, 2, 0);
        wait_state(3'h5, n);
        chk({fault_latched_q, output_enable_q, attempts_q}, 10'h202);
        pf(0);
        chk(seq_state_q, 3'h5);
        pf(2);
        wait_state(3'h1, n);
        chk(seq_state_q, 3'h1);
        retry(3'h6, 6, 0);
        wait_state(3'h5, n);
        chk(attempts_q, 8'h06);
        output_cmd_on = 1'b0;
        tick;
        tick;
        chk({seq_state_q, attempts_q}, 0);
        output_cmd_on = 1'b1;
        wait_state(3'h1, n);
        retry(3'h0, 0, 0);
        wait_state(3'h5, n);
        near(n, 8 * UNIT);
        pf(3);
        wait_state(3'h1, n);
        retry(3'h2, 2, 2);
        chk(seq_state_q, 3'h1);
        retry(3'h7, 9, 0);
        wait_state(3'h4, n);
        chk(attempts_q, 8'h0a);
        pf(4);
        chk(seq_state_q, 3'h5);
        pf(2);
        wait_state(3'h1, n);
        retry(3'h7, 2, 0);
        bias_lost = 1'b1;
        tick;
        tick;
        chk(seq_state_q, 3'h0);
        bias_lost = 1'b0;
        wait_state(3'h1, n);
        chk(seq_state_q, 3'h1);
        stop_test;
    end
endmodule // frpg_top_bench
